// [pkg/wps_defines.vh]
// Constants for the path status overhead block: register offsets,
// field positions, reset values, G1 codes and persistence counts.
// Assumes inclusion by bare name from the design directory search path.
`ifndef WPS_DEFINES_VH
`define WPS_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WPS_OFF_CTRL        8'h00
`define WPS_OFF_LIVE        8'h04
`define WPS_OFF_PEND        8'h08
`define WPS_OFF_MASK_A      8'h0c
`define WPS_OFF_MASK_B      8'h10
`define WPS_OFF_TX_USER     8'h14
`define WPS_OFF_TX_MFRAME   8'h18
`define WPS_OFF_TX_G1       8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WPS_CTRL_RX_ENH     0
`define WPS_CTRL_TX_ENH     1
`define WPS_CTRL_TIM_FORCE  2
`define WPS_EV_REMOTE       0
`define WPS_EV_UNEQ         1
`define WPS_EV_PAYLOAD      2
`define WPS_EV_SERVER       3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WPS_RST_CTRL        3'h3
`define WPS_RST_MASK        4'h0
`define WPS_RST_TX_USER     8'h00
`define WPS_RST_TX_MFRAME   8'h00

// ----------------------------------------------------------------
// Path status byte codes (bits 5..7) and limits
// ----------------------------------------------------------------
`define WPS_CODE_NONE_ENH   3'h1
`define WPS_CODE_PAYLOAD    3'h2
`define WPS_CODE_SERVER     3'h5
`define WPS_CODE_CONNECT    3'h6
`define WPS_CODE_RDI_SET    3'h4
`define WPS_CODE_RDI_CLR    3'h0
`define WPS_REI_MAX         4'h8
`define WPS_PERSIST_LAST    4'h9
`define WPS_FIFO_DEPTH      4
`define WPS_FIFO_AW         2

`endif

// [design/wps_path_status.v]
// Path status overhead: builds the transmitted G1, F2 and H4 bytes and
// parses the received G1 byte into far-end defects, events and IRQs.
// Assumes frame strobes, defect levels and the Avalon-MM master all run
// on ref_clk_i; no input here needs synchronising.
`timescale 1ns/100ps
`include "wps_defines.vh"

module wps_path_status (
    // Clock and reset
    input  wire        ref_clk_i,
    input  wire        resetn_i,
    // Avalon-MM slave
    input  wire [7:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // Receive frame side
    input  wire        rx_frame_i,
    input  wire [7:0]  rx_g1_i,
    input  wire        rx_b3_valid_i,
    input  wire [3:0]  rx_b3_count_i,
    // Near-end defect levels
    input  wire        ne_path_ais_i,
    input  wire        ne_path_lop_i,
    input  wire        ne_path_plm_i,
    input  wire        ne_path_lcd_i,
    input  wire        ne_path_uneq_i,
    // Transmit frame side
    input  wire        tx_frame_i,
    output wire        tx_valid_o,
    output wire [7:0]  tx_g1_o,
    output wire [7:0]  tx_user_channel_value_o,
    output wire [7:0]  tx_multiframe_byte_value_o,
    // Interrupts
    output wire        path_irq_out_a,
    output wire        path_irq_out_b
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg  [2:0]  ctrl_q;
    reg  [3:0]  mask_a_q;
    reg  [3:0]  mask_b_q;
    reg  [7:0]  tx_user_channel_value;
    reg  [7:0]  tx_multiframe_byte_value;
    reg  [3:0]  pend_q;
    reg  [3:0]  pend_d;
    reg         payload_latched_q;
    reg         server_latched_q;
    reg         defect_state_q;
    reg  [3:0]  persist_cnt_q;
    reg  [2:0]  last_code_q;
    reg         ack_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         irq_a_q;
    reg         irq_b_q;
    reg         tx_valid_q;
    reg  [7:0]  tx_g1_q;
    reg  [7:0]  tx_user_channel_value_q;
    reg  [7:0]  tx_multiframe_byte_value_q;
    reg  [3:0]  fifo_mem [0:`WPS_FIFO_DEPTH-1];
    reg  [`WPS_FIFO_AW:0] wr_ptr_q;
    reg  [`WPS_FIFO_AW:0] rd_ptr_q;
    reg  [2:0]  tx_code;
    reg  [3:0]  ev_set;

    wire        rx_enhanced_defect_select;
    wire        tx_enhanced_defect_select;
    wire        tim_force;
    wire        req;
    wire        accept;
    wire        wr_hit;
    wire        rd_pend;
    wire        rd_live;
    wire [2:0]  rx_code;
    wire        rx_sig;
    wire        sig_diff;
    wire        declare_chg;
    wire        code_new;
    wire        fifo_empty;
    wire        fifo_full;
    wire        fifo_push;
    wire        fifo_pop;
    wire [3:0]  b3_clamped;
    wire [3:0]  rei_value;
    wire        far_end_remote_defect_live;
    wire        far_end_unequipped_live;
    wire        far_end_remote_defect_pending;
    wire        far_end_unequipped_pending;
    wire        far_end_payload_defect_pending;
    wire        far_end_server_defect_pending;
    wire [3:0]  route_a;
    wire [3:0]  route_b;

    assign rx_enhanced_defect_select = ctrl_q[`WPS_CTRL_RX_ENH];
    assign tx_enhanced_defect_select = ctrl_q[`WPS_CTRL_TX_ENH];
    assign tim_force                 = ctrl_q[`WPS_CTRL_TIM_FORCE];

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait cycle lets read data come straight from a flop
    assign req               = avs_read_i | avs_write_i;
    assign accept            = req & ack_q;
    assign avs_waitrequest_o = req & ~ack_q;
    assign avs_readdata_o    = rdata_q;
    assign wr_hit            = accept & avs_write_i & avs_byteenable_i[0];
    assign rd_pend = accept & avs_read_i &
                     (avs_address_i[7:2] == `WPS_OFF_PEND >> 2);
    assign rd_live = accept & avs_read_i &
                     (avs_address_i[7:2] == `WPS_OFF_LIVE >> 2);

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q                   <= `WPS_RST_CTRL;
            mask_a_q                 <= `WPS_RST_MASK;
            mask_b_q                 <= `WPS_RST_MASK;
            tx_user_channel_value    <= `WPS_RST_TX_USER;
            tx_multiframe_byte_value <= `WPS_RST_TX_MFRAME;
        end else if (wr_hit) begin
            case (avs_address_i[7:2])
                `WPS_OFF_CTRL >> 2: begin
                    ctrl_q <= avs_writedata_i[2:0];
                end
                `WPS_OFF_MASK_A >> 2: begin
                    mask_a_q <= avs_writedata_i[3:0];
                end
                `WPS_OFF_MASK_B >> 2: begin
                    mask_b_q <= avs_writedata_i[3:0];
                end
                `WPS_OFF_TX_USER >> 2: begin
                    tx_user_channel_value <= avs_writedata_i[7:0];
                end
                `WPS_OFF_TX_MFRAME >> 2: begin
                    tx_multiframe_byte_value <= avs_writedata_i[7:0];
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @* begin
        rdata_d = 32'h0000_0000;
        case (avs_address_i[7:2])
            `WPS_OFF_CTRL >> 2:      rdata_d[2:0] = ctrl_q;
            `WPS_OFF_LIVE >> 2: begin
                rdata_d[`WPS_EV_REMOTE]  = far_end_remote_defect_live;
                rdata_d[`WPS_EV_UNEQ]    = far_end_unequipped_live;
                rdata_d[`WPS_EV_PAYLOAD] = payload_latched_q;
                rdata_d[`WPS_EV_SERVER]  = server_latched_q;
            end
            `WPS_OFF_PEND >> 2:      rdata_d[3:0] = pend_q;
            `WPS_OFF_MASK_A >> 2:    rdata_d[3:0] = mask_a_q;
            `WPS_OFF_MASK_B >> 2:    rdata_d[3:0] = mask_b_q;
            `WPS_OFF_TX_USER >> 2:   rdata_d[7:0] = tx_user_channel_value;
            `WPS_OFF_TX_MFRAME >> 2: rdata_d[7:0] = tx_multiframe_byte_value;
            `WPS_OFF_TX_G1 >> 2:     rdata_d[7:0] = tx_g1_q;
            default:                 rdata_d = 32'h0000_0000;
        endcase
    end

    // Sampled in the wait cycle, so the value shows at the accept edge
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read_i & ~ack_q) begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Receive G1 parsing and persistence
    // ------------------------------------------------------------
    // bits 5-7 are g1[3:1]; bit 8 (g1[0]) is ignored
    assign rx_code = rx_g1_i[3:1];

    // single reading looks at bit 5 only, so 000/011 and 100/111 pair
    assign rx_sig = rx_enhanced_defect_select ?
                    ((rx_code == `WPS_CODE_PAYLOAD) |
                     (rx_code == `WPS_CODE_SERVER)  |
                     (rx_code == `WPS_CODE_CONNECT)) :
                    rx_g1_i[3];

    assign sig_diff    = rx_frame_i & (rx_sig != defect_state_q);
    assign declare_chg = sig_diff & (persist_cnt_q == `WPS_PERSIST_LAST);

    // declare after ten frames in single mode
    // clear after ten clean frames in single mode
    // declare after ten enhanced defect frames
    // clear after ten frames without enhanced defect
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            defect_state_q <= 1'b0;
            persist_cnt_q  <= 4'h0;
        end else if (rx_frame_i) begin
            if (declare_chg) begin
                defect_state_q <= ~defect_state_q;
                persist_cnt_q  <= 4'h0;
            end else if (sig_diff) begin
                persist_cnt_q <= persist_cnt_q + 4'h1;
            end else begin
                persist_cnt_q <= 4'h0;
            end
        end
    end

    // Last received code, to fire code events once per arrival
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_code_q <= `WPS_CODE_NONE_ENH;
        end else if (rx_frame_i) begin
            last_code_q <= rx_code;
        end
    end

    assign code_new = rx_frame_i & rx_enhanced_defect_select &
                      (rx_code != last_code_q);

    assign far_end_remote_defect_live = defect_state_q;
    // live unequipped while declared on the connectivity code
    assign far_end_unequipped_live = defect_state_q &
                                     rx_enhanced_defect_select &
                                     (last_code_q == `WPS_CODE_CONNECT);

    // ------------------------------------------------------------
    // Events, pending and latched status
    // ------------------------------------------------------------
    always @* begin
        ev_set = 4'h0;
        // declare or clear is a remote defect event
        ev_set[`WPS_EV_REMOTE]  = declare_chg;
        ev_set[`WPS_EV_UNEQ]    = code_new &
                                  (rx_code == `WPS_CODE_CONNECT);
        ev_set[`WPS_EV_PAYLOAD] = code_new &
                                  (rx_code == `WPS_CODE_PAYLOAD);
        ev_set[`WPS_EV_SERVER]  = code_new &
                                  (rx_code == `WPS_CODE_SERVER);
    end

    // read clears only bits it returned, so a bit set in the wait
    // cycle is not lost; a same-cycle event wins
    always @* begin
        pend_d = (pend_q & ~(rdata_q[3:0] & {4{rd_pend}})) | ev_set;
    end

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_q            <= 4'h0;
            payload_latched_q <= 1'b0;
            server_latched_q  <= 1'b0;
        end else begin
            pend_q <= pend_d;
            // latch-high payload status, cleared by status read
            payload_latched_q <= ev_set[`WPS_EV_PAYLOAD] |
                                 (payload_latched_q &
                                  ~(rd_live & rdata_q[`WPS_EV_PAYLOAD]));
            // latch-high server status, cleared by status read
            server_latched_q  <= ev_set[`WPS_EV_SERVER] |
                                 (server_latched_q &
                                  ~(rd_live & rdata_q[`WPS_EV_SERVER]));
        end
    end

    assign far_end_remote_defect_pending  = pend_q[`WPS_EV_REMOTE];
    assign far_end_unequipped_pending     = pend_q[`WPS_EV_UNEQ];
    assign far_end_payload_defect_pending = pend_q[`WPS_EV_PAYLOAD];
    assign far_end_server_defect_pending  = pend_q[`WPS_EV_SERVER];

    // ------------------------------------------------------------
    // Interrupt routing
    // ------------------------------------------------------------
    // per-event mask gates each output
    // unequipped shares the remote defect mask bits
    assign route_a = {far_end_server_defect_pending  & mask_a_q[3],
                      far_end_payload_defect_pending & mask_a_q[2],
                      far_end_unequipped_pending     & mask_a_q[0],
                      far_end_remote_defect_pending  & mask_a_q[0]};
    assign route_b = {far_end_server_defect_pending  & mask_b_q[3],
                      far_end_payload_defect_pending & mask_b_q[2],
                      far_end_unequipped_pending     & mask_b_q[0],
                      far_end_remote_defect_pending  & mask_b_q[0]};

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_a_q <= 1'b0;
            irq_b_q <= 1'b0;
        end else begin
            irq_a_q <= |route_a;
            irq_b_q <= |route_b;
        end
    end

    assign path_irq_out_a = irq_a_q;
    assign path_irq_out_b = irq_b_q;

    // ------------------------------------------------------------
    // B3 error count FIFO
    // ------------------------------------------------------------
    // counts queue from receive side to transmit side
    // full drops the count silently, empty gives zero
    assign fifo_empty = (wr_ptr_q == rd_ptr_q);
    assign fifo_full  = (wr_ptr_q[`WPS_FIFO_AW] != rd_ptr_q[`WPS_FIFO_AW]) &
                        (wr_ptr_q[`WPS_FIFO_AW-1:0] ==
                         rd_ptr_q[`WPS_FIFO_AW-1:0]);
    assign fifo_push  = rx_b3_valid_i & ~fifo_full;
    assign fifo_pop   = tx_frame_i & ~fifo_empty;
    assign b3_clamped = (rx_b3_count_i > `WPS_REI_MAX) ?
                        `WPS_REI_MAX : rx_b3_count_i;
    assign rei_value  = fifo_empty ? 4'h0 :
                        fifo_mem[rd_ptr_q[`WPS_FIFO_AW-1:0]];

    // Storage needs no reset; only pointers define content
    always @(posedge ref_clk_i) begin
        if (fifo_push) begin
            fifo_mem[wr_ptr_q[`WPS_FIFO_AW-1:0]] <= b3_clamped;
        end
    end

    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_q <= {(`WPS_FIFO_AW+1){1'b0}};
            rd_ptr_q <= {(`WPS_FIFO_AW+1){1'b0}};
        end else begin
            if (fifo_push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (fifo_pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit G1 code selection
    // ------------------------------------------------------------
    always @* begin
        tx_code = `WPS_CODE_RDI_CLR;
        if (tx_enhanced_defect_select) begin
            // highest priority first, else no-defect code
            // server on alarm indication or pointer loss
            if (ne_path_ais_i | ne_path_lop_i) begin
                tx_code = `WPS_CODE_SERVER;
            end else if (ne_path_uneq_i | tim_force) begin
                tx_code = `WPS_CODE_CONNECT;
            // payload on label mismatch or delineation loss
            end else if (ne_path_plm_i | ne_path_lcd_i) begin
                tx_code = `WPS_CODE_PAYLOAD;
            end else begin
                tx_code = `WPS_CODE_NONE_ENH;
            end
        end else begin
            // single mode, bits 6-7 sent as zero
            // defect flag on alarm indication or pointer loss
            if (ne_path_ais_i | ne_path_lop_i) begin
                tx_code = `WPS_CODE_RDI_SET;
            end else begin
                tx_code = `WPS_CODE_RDI_CLR;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit byte registers
    // ------------------------------------------------------------
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_valid_q <= 1'b0;
            tx_g1_q    <= 8'h00;
            tx_user_channel_value_q    <= `WPS_RST_TX_USER;
            tx_multiframe_byte_value_q    <= `WPS_RST_TX_MFRAME;
        end else begin
            tx_valid_q <= tx_frame_i;
            if (tx_frame_i) begin
                // error count in bits 1-4, bit 8 sent zero
                tx_g1_q <= {rei_value, tx_code, 1'b0};
                tx_user_channel_value_q <= tx_user_channel_value;
                tx_multiframe_byte_value_q <= tx_multiframe_byte_value;
            end
        end
    end

    assign tx_valid_o = tx_valid_q;
    assign tx_g1_o    = tx_g1_q;
    assign tx_user_channel_value_o    = tx_user_channel_value_q;
    assign tx_multiframe_byte_value_o    = tx_multiframe_byte_value_q;

endmodule

// [bench/wps_path_status_asserts.sv]
// Checker for wps_path_status: bus wait state, transmit G1 and IRQ A.
// Assumes top-level ports only; it mirrors CTRL and MASK_A writes.
`timescale 1ns/100ps
module wps_path_status_asserts (
    input wire        ref_clk_i,
    input wire        resetn_i,
    input wire [7:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0]  avs_byteenable_i,
    input wire        avs_waitrequest_o,
    input wire        ne_path_ais_i,
    input wire        ne_path_lop_i,
    input wire        ne_path_plm_i,
    input wire        ne_path_lcd_i,
    input wire        ne_path_uneq_i,
    input wire        tx_frame_i,
    input wire        tx_valid_o,
    input wire [7:0]  tx_g1_o,
    input wire        path_irq_out_a
);
    logic [2:0] ctrl_q;
    logic       mask_q;
    wire        hit = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    wire        srv = ne_path_ais_i | ne_path_lop_i;
    wire        con = ne_path_uneq_i | ctrl_q[2];
    wire        pay = ne_path_plm_i | ne_path_lcd_i;
    wire        enh = ctrl_q[1];
    // Mirror only what the code choice and the IRQ A mask check depend on
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= 3'h3;
            mask_q <= 1'b0;
        end else if (hit && avs_address_i[7:2] == 6'h00) begin
            ctrl_q <= avs_writedata_i[2:0];
        end else if (hit && avs_address_i[7:2] == 6'h03) begin
            mask_q <= |avs_writedata_i[3:0];
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_wait;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    a_one_wait: assert property ($rose(avs_read_i | avs_write_i) |-> s_wait)
        else $error("wait state count wrong");
    a_tx_valid: assert property (tx_frame_i |=> tx_valid_o)
        else $error("tx valid missing");
    a_rei_range: assert property (tx_valid_o |-> tx_g1_o[7:4] <= 4'h8)
        else $error("remote error out of range");
    a_server_code: assert property (tx_frame_i && enh && srv |=> tx_g1_o[3:1] == 3'h5)
        else $error("server code wrong");
    a_conn_code: assert property (tx_frame_i && enh && !srv && con |=> tx_g1_o[3:1] == 3'h6)
        else $error("connectivity code wrong");
    a_payload_code: assert property (tx_frame_i && enh && !srv && !con && pay |=> tx_g1_o[3:1] == 3'h2)
        else $error("payload code wrong");
    a_none_code: assert property (tx_frame_i && enh && !srv && !con && !pay |=> tx_g1_o[3:1] == 3'h1)
        else $error("no-defect code wrong");
    a_single_code: assert property (tx_frame_i && !enh |=> tx_g1_o[3:0] == {srv, 3'h0})
        else $error("single-bit code wrong");
    a_irq_masked: assert property (!mask_q && !$past(mask_q) |-> !path_irq_out_a)
        else $error("irq a raised while masked");
endmodule
bind wps_path_status wps_path_status_asserts u_chk (.*);

// [bench/wps_far_end.sv]
// Far-end path endpoint model: sends received frames carrying G1.
// Assumes one caller of send() at a time, on the block's clock.
`timescale 1ns/100ps
module wps_far_end (
    // Clock
    input  wire        ref_clk_i,
    // Frame side
    output logic       frame_o,
    output logic [7:0] g1_o
);
    logic spare_q = 1'b0;
    initial begin
        frame_o = 1'b0;
        g1_o    = 8'hff;
    end
    // code in bits 5-7, spare toggles
    task automatic send(input logic [7:0] g1, input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            frame_o <= 1'b1;
            g1_o    <= {g1[7:1], spare_q};
            spare_q <= ~spare_q;
            @(posedge ref_clk_i);
            frame_o <= 1'b0;
            g1_o    <= ~g1;
            repeat (2) @(posedge ref_clk_i);
        end
    endtask
endmodule

// [bench/wps_path_status_test.sv]
// Testbench for wps_path_status: registers, transmit bytes, far-end G1.
// Assumes the design, far-end model and checker compile before it.
`timescale 1ns/100ps
`include "wps_defines.vh"
module wps_path_status_test;
    logic        clk = 1'b0, rstn = 1'b0, rd_s = 1'b0, wr_s = 1'b0;
    logic        txf = 1'b0, b3v = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic [3:0]  b3c = 4'h0;
    logic [4:0]  ne = 5'h00;
    wire  [31:0] rdat;
    wire  [7:0]  g1, f2, h4, rxg;
    wire         wt, txv, ia, ib, rxf;
    int          fails = 0, num_checks = 0;
    always #10 clk = ~clk;
    wps_path_status u_wps_path_status (.ref_clk_i(clk), .resetn_i(rstn),
        .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .rx_frame_i(rxf), .rx_g1_i(rxg),
        .rx_b3_valid_i(b3v), .rx_b3_count_i(b3c), .ne_path_ais_i(ne[4]),
        .ne_path_lop_i(ne[3]), .ne_path_plm_i(ne[2]), .ne_path_lcd_i(ne[1]),
        .ne_path_uneq_i(ne[0]), .tx_frame_i(txf), .tx_valid_o(txv),
        .tx_g1_o(g1), .tx_user_channel_value_o(f2), .tx_multiframe_byte_value_o(h4), .path_irq_out_a(ia),
        .path_irq_out_b(ib));
    wps_far_end u_wps_far_end (.ref_clk_i(clk), .frame_o(rxf), .g1_o(rxg));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        {rd_s, wr_s, adr, wd} <= {!w, w, a, d};
        do @(posedge clk); while (wt !== 1'b0);
        r = rdat;
        {rd_s, wr_s} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(n, e, r);
    endtask
    task tx(input string n, input logic [7:0] e);
        @(posedge clk) txf <= 1'b1;
        @(posedge clk) txf <= 1'b0;
        @(negedge clk);
        chk("tx valid", 1, txv);
        chk(n, e, g1);
    endtask
    task t_reset;
        rd("ctrl", `WPS_OFF_CTRL, 3);
        rd("mask a", `WPS_OFF_MASK_A, 0);
        rd("f2", `WPS_OFF_TX_USER, 0);
        rd("h4", `WPS_OFF_TX_MFRAME, 0);
        rd("bad addr", 8'hfc, 0);
        tx("idle g1", 8'h02);
    endtask
    task automatic t_codes;
        logic [4:0] dv [7] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h05, 5'h11};
        logic [7:0] ev [7] = '{8'h0a, 8'h0a, 8'h04, 8'h04, 8'h0c, 8'h0c, 8'h0a};
        for (int i = 0; i < 7; i++) begin
            @(posedge clk) ne <= dv[i];
            tx("enh code", ev[i]);
        end
        @(posedge clk) ne <= 5'h00;
        wr(`WPS_OFF_CTRL, 7);
        tx("forced trace", 8'h0c);
        wr(`WPS_OFF_CTRL, 1);
        @(posedge clk) ne <= 5'h10;
        tx("single set", 8'h08);
        @(posedge clk) ne <= 5'h00;
        tx("single clear", 8'h00);
        wr(`WPS_OFF_CTRL, 3);
    endtask
    task t_rei_bytes;
        @(posedge clk) {b3v, b3c} <= 5'h13;
        @(posedge clk) {b3v, b3c} <= 5'h19;
        @(posedge clk) b3v <= 1'b0;
        tx("rei 3", 8'h32);
        tx("rei clamp", 8'h82);
        wr(`WPS_OFF_TX_USER, 32'ha5);
        wr(`WPS_OFF_TX_MFRAME, 32'h3c);
        tx("rei empty", 8'h02);
        chk("f2", 32'ha5, {24'h0, f2});
        chk("h4", 32'h3c, {24'h0, h4});
    endtask
    task t_rx_enh;
        wr(`WPS_OFF_MASK_A, 9);
        wr(`WPS_OFF_MASK_B, 8);
        u_wps_far_end.send(8'h0a, 9);
        rd("live 9", `WPS_OFF_LIVE, 8);
        u_wps_far_end.send(8'h0a, 1);
        rd("live 10", `WPS_OFF_LIVE, 1);
        chk("irq a", 1, ia);
        chk("irq b", 1, ib);
        rd("pend", `WPS_OFF_PEND, 9);
        rd("pend clr", `WPS_OFF_PEND, 0);
        repeat (2) @(negedge clk);
        chk("irq b low", 0, ib);
        u_wps_far_end.send(8'h02, 10);
        rd("live end", `WPS_OFF_LIVE, 0);
        rd("pend end", `WPS_OFF_PEND, 1);
        u_wps_far_end.send(8'h0c, 1);
        rd("pend uneq", `WPS_OFF_PEND, 2);
        u_wps_far_end.send(8'h04, 1);
        u_wps_far_end.send(8'h02, 1);
        rd("pend payload", `WPS_OFF_PEND, 4);
        rd("live payload", `WPS_OFF_LIVE, 4);
        u_wps_far_end.send(8'h0c, 10);
        rd("live uneq", `WPS_OFF_LIVE, 3);
        u_wps_far_end.send(8'h02, 10);
    endtask
    task t_rx_single;
        wr(`WPS_OFF_CTRL, 2);
        u_wps_far_end.send(8'h08, 10);
        rd("single live", `WPS_OFF_LIVE, 1);
        u_wps_far_end.send(8'h06, 10);
        rd("single end", `WPS_OFF_LIVE, 0);
        chk("irq a single", 1, ia);
        wr(`WPS_OFF_MASK_A, 0);
        repeat (2) @(negedge clk);
        chk("irq a masked", 0, ia);
    endtask
    task complete_run;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_codes;
        t_rei_bytes;
        t_rx_enh;
        t_rx_single;
        complete_run;
    end
endmodule
